// [core/switchgear_object_control_monitor.sv]
// switchgear object control and position monitoring
`timescale 1ns/1ps
`include "object_ctrl_consts.svh"
module switchgear_object_control_monitor #(
   parameter int PULSE_LEN = `CMD_PULSE_CYCLES
) (
   input  wire logic                               sys_clk,
   input  wire logic                               rst,
   input  wire object_ctrl_pkg::cfg_type           cfg,
   input  wire object_ctrl_pkg::pins_type          pins,
   input  wire logic                               syncResult,
   input  wire object_ctrl_pkg::cmd_type           cmd,
   input  wire logic                               setLocal,
   input  wire logic                               setRemote,
   input  wire logic                               statClear,
   input  wire logic                               nameLoad,
   input  wire logic [`NAME_CHARS*8-1:0]           nameIn,
   output logic                                    openCmd,
   output logic                                    closeCmd,
   output object_ctrl_pkg::pos_type                breakerPos,
   output object_ctrl_pkg::cart_pos_type           cartPos,
   output object_ctrl_pkg::flags_type              flags,
   output object_ctrl_pkg::status_type             objStatus,
   output logic                                    localActive,
   output logic [`CNT_NUM-1:0][`COUNT_WIDTH-1:0]   requestCounts,
   output logic [`NAME_CHARS*8-1:0]                objectName
);
   import object_ctrl_pkg::*;

   typedef enum {S_IDLE, S_OPENING, S_CLOSING} ctrl_state_type;

   localparam int PW = $clog2(PULSE_LEN + 1);

   ctrl_state_type                 state_reg;
   ctrl_state_type                 state_next;
   logic [PW-1:0]                  pulseCnt_reg;
   logic [PW-1:0]                  pulseCnt_next;
   pins_type                       pinMeta_reg;
   pins_type                       pinSync_reg;
   logic                           openCmd_reg;
   logic                           closeCmd_reg;
   pos_type                        breakerPos_reg;
   cart_pos_type                   cartPos_reg;
   cart_pos_type                   cartPos_next;
   flags_type                      flags_reg;
   flags_type                      flags_next;
   status_type                     status_reg;
   status_type                     status_next;
   status_type                     objStatus_reg;
   status_type                     objStatus_next;
   logic                           local_reg;
   logic                           local_next;
   logic                           armed_reg;
   logic                           armed_next;
   logic [`NAME_CHARS*8-1:0]       objectName_reg;
   logic [`CNT_NUM-1:0]            cntInc;
   pos_type                        breakerDec;
   pos_type                        cartDec;

   // input contacts pass two flip-flops
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pinMeta_reg <= '0;
         pinSync_reg <= '0;
      end else begin
         pinMeta_reg <= pins;
         pinSync_reg <= pinMeta_reg;
      end
   end

   wire closeSense = cfg.singleInput ? !pinSync_reg.openStatus
                                     : pinSync_reg.closeStatus;

   position_decoder breakerDecode (
      .awayIn (pinSync_reg.openStatus),
      .homeIn (closeSense),
      .pos    (breakerDec)
   );

   position_decoder cartDecode (
      .awayIn (pinSync_reg.cartOut),
      .homeIn (pinSync_reg.cartIn),
      .pos    (cartDec)
   );

   wire cartMonitored = (cfg.objKind == OBJ_WD_BREAKER);
   wire isBreaker     = (cfg.objKind == OBJ_BREAKER) || cartMonitored;
   wire controllable  = (cfg.objKind != OBJ_DISC_GND);

   always_comb begin
      cartPos_next = CART_UNUSED;
      if (cartMonitored) begin
         case (cartDec)
            POS_INTERMEDIATE: cartPos_next = CART_POSITION_INTERMEDIATE;
            POS_OPEN:         cartPos_next = CART_WITHDRAWN;
            POS_CLOSED:       cartPos_next = CART_INSERTED;
            POS_BAD:          cartPos_next = CART_POSITION_INVALID;
            default:          cartPos_next = CART_UNUSED;
         endcase
      end
   end

   wire syncSel  = cfg.syncFromPin ? pinSync_reg.extSync : syncResult;
   wire syncOkW  = !isBreaker || !cfg.useSync || syncSel;
   wire readyLvl = (cfg.readyMode == READY_HIGH) ? pinSync_reg.readyIn :
                   (cfg.readyMode == READY_LOW) ? !pinSync_reg.readyIn :
                   1'b1;
   wire readyOkW = !isBreaker || readyLvl;

   wire srcLocal  = (cmd.source == SRC_LOCAL);
   wire srcRemote = (cmd.source == SRC_REMOTE);
   wire srcAuto   = (cmd.source == SRC_AUTO);
   wire anyReq    = cmd.openReq || cmd.closeReq;
   // execute needs prior select in that mode
   wire remoteOk  = srcRemote && !local_reg &&
                    (!cfg.selectBeforeExecute || armed_reg);
   wire authOk    = srcAuto || (srcLocal && local_reg) || remoteOk;

   wire idle      = (state_reg == S_IDLE);
   wire wantOpen  = cmd.openReq;
   wire wantClose = cmd.closeReq && !cmd.openReq;
   wire accepted  = authOk && controllable;
   wire openGo    = idle && accepted && wantOpen;
   wire closeTake = idle && accepted && wantClose;
   wire closeGo   = closeTake && syncOkW && readyOkW;
   wire closeRej  = closeTake && !closeGo;
   wire openBusy  = !idle && accepted && wantOpen;
   wire closeBusy = !idle && accepted && wantClose;

   // select arms, any remote execute disarms
   always_comb begin
      armed_next = armed_reg;
      if (local_next != local_reg) begin
         armed_next = 1'b0;
      end else if (srcRemote && anyReq) begin
         armed_next = 1'b0;
      end else if (srcRemote && cmd.selectReq && !local_reg) begin
         armed_next = cfg.selectBeforeExecute;
      end
   end

   assign local_next = setLocal ? 1'b1 : setRemote ? 1'b0 : local_reg;

   always_comb begin
      state_next    = state_reg;
      pulseCnt_next = pulseCnt_reg;
      case (state_reg)
         S_IDLE: begin
            pulseCnt_next = '0;
            if (openGo) begin
               state_next = S_OPENING;
            end else if (closeGo) begin
               state_next = S_CLOSING;
            end
         end
         S_OPENING, S_CLOSING: begin
            if (pulseCnt_reg == PW'(PULSE_LEN - 1)) begin
               state_next    = S_IDLE;
               pulseCnt_next = '0;
            end else begin
               pulseCnt_next = pulseCnt_reg + 1'b1;
            end
         end
         default: begin
            state_next    = S_IDLE;
            pulseCnt_next = '0;
         end
      endcase
   end

   always_comb begin
      status_next = status_reg;
      if (openGo) begin
         status_next = srcLocal ? ST_USER_OPEN_REQUEST : ST_OPEN_SIGNAL;
      end else if (closeGo) begin
         status_next = srcLocal ? ST_USER_CLOSE_REQUEST : ST_CLOSE_SIGNAL;
      end else if (closeRej) begin
         status_next = !readyOkW ? ST_READY_FAILURE : ST_SYNC_FAILURE;
      end else if (idle && (status_reg == ST_OPEN_SIGNAL ||
                            status_reg == ST_CLOSE_SIGNAL ||
                            status_reg == ST_USER_OPEN_REQUEST ||
                            status_reg == ST_USER_CLOSE_REQUEST)) begin
         status_next = ST_NORMAL;
      end
   end

   assign objStatus_next = (cfg.forceEnable && cfg.forceState != ST_NORMAL)
                           ? cfg.forceState : status_next;

   assign flags_next.openAllowed  = controllable && (state_next == S_IDLE);
   assign flags_next.closeAllowed = controllable &&
                                    (state_next == S_IDLE) &&
                                    syncOkW && readyOkW;
   assign flags_next.objectReady  = readyOkW;
   assign flags_next.syncOk       = syncOkW;

   assign cntInc[`CNT_OPEN_OK]    = openGo;
   assign cntInc[`CNT_CLOSE_OK]   = closeGo;
   assign cntInc[`CNT_OPEN_FAIL]  = openBusy;
   assign cntInc[`CNT_CLOSE_FAIL] = closeRej || closeBusy;

   genvar gi;
   generate
      for (gi = 0; gi < `CNT_NUM; gi++) begin : gCnt
         request_counter #(.WIDTH(`COUNT_WIDTH)) counter (
            .sys_clk (sys_clk),
            .rst     (rst),
            .inc     (cntInc[gi]),
            .clr     (statClear),
            .count   (requestCounts[gi])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg      <= S_IDLE;
         pulseCnt_reg   <= '0;
         openCmd_reg    <= 1'b0;
         closeCmd_reg   <= 1'b0;
         breakerPos_reg <= POS_INTERMEDIATE;
         cartPos_reg    <= CART_UNUSED;
         flags_reg      <= '0;
         status_reg     <= ST_NORMAL;
         objStatus_reg  <= ST_NORMAL;
         local_reg      <= `RST_LOCAL_SEL;
         armed_reg      <= `RST_ARMED;
      end else begin
         state_reg      <= state_next;
         pulseCnt_reg   <= pulseCnt_next;
         openCmd_reg    <= (state_next == S_OPENING);
         closeCmd_reg   <= (state_next == S_CLOSING);
         breakerPos_reg <= breakerDec;
         cartPos_reg    <= cartPos_next;
         flags_reg      <= flags_next;
         status_reg     <= status_next;
         objStatus_reg  <= objStatus_next;
         local_reg      <= local_next;
         armed_reg      <= armed_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         objectName_reg <= '0;
      end else if (nameLoad) begin
         objectName_reg <= nameIn;
      end
   end

   // configuration sampled live, held static by setup
   assign openCmd     = openCmd_reg;
   assign closeCmd    = closeCmd_reg;
   assign breakerPos  = breakerPos_reg;
   assign cartPos     = cartPos_reg;
   assign flags       = flags_reg;
   assign objStatus   = objStatus_reg;
   assign localActive = local_reg;
   assign objectName  = objectName_reg;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_pos_intermediate: assert property (
      (!pinSync_reg.openStatus && !closeSense)
      |=> breakerPos_reg == POS_INTERMEDIATE)
      else $error("intermediate position not reported");

   chk_pos_bad: assert property (
      (pinSync_reg.openStatus && closeSense)
      |=> breakerPos_reg == POS_BAD)
      else $error("bad position not reported");

   chk_cart_invalid: assert property (
      (cartMonitored && pinSync_reg.cartIn && pinSync_reg.cartOut)
      |=> cartPos_reg == CART_POSITION_INVALID)
      else $error("cart invalid not reported");

   chk_cart_unused: assert property (
      !cartMonitored |=> cartPos_reg == CART_UNUSED)
      else $error("cart not reported unused");

   chk_remote_blocks_local: assert property (
      (idle && srcLocal && anyReq && !local_reg)
      |=> !openCmd_reg && !closeCmd_reg)
      else $error("local command taken in remote");

   chk_local_blocks_remote: assert property (
      (idle && srcRemote && anyReq && local_reg)
      |=> !openCmd_reg && !closeCmd_reg)
      else $error("remote command taken in local");

   chk_sync_gate: assert property (
      $rose(closeCmd_reg) |-> $past(syncOkW))
      else $error("close issued without sync");

   chk_ready_gate: assert property (
      $rose(closeCmd_reg) |-> $past(readyOkW))
      else $error("close issued while not ready");

   chk_cmd_exclusive: assert property (
      $rose(openCmd_reg) |-> !closeCmd_reg ##1 !closeCmd_reg)
      else $error("open and close driven together");

   chk_force_status: assert property (
      (cfg.forceEnable && cfg.forceState != ST_NORMAL)
      |=> objStatus_reg == $past(cfg.forceState))
      else $error("forced status not shown");

   chk_clear_counts: assert property (
      statClear |=> requestCounts == '0)
      else $error("counters not cleared");

   chk_close_reject: assert property (
      closeRej |=> !closeCmd_reg && !flags_reg.closeAllowed)
      else $error("blocked close not rejected");

   cov_open_issued:  cover property (openGo ##1 openCmd_reg);
   cov_close_reject: cover property (closeRej);
   cov_sbe_execute:  cover property (armed_reg && srcRemote && closeGo);
   cov_stat_clear:   cover property (statClear && requestCounts != '0);
endmodule

// [core/object_ctrl_consts.svh]
// constants of the switchgear object control block
`ifndef OBJECT_CTRL_CONSTS_SVH
`define OBJECT_CTRL_CONSTS_SVH
`define NAME_CHARS        32
`define COUNT_WIDTH       32
`define CMD_PULSE_CYCLES  16
`define CNT_NUM           4
`define CNT_OPEN_OK       0
`define CNT_CLOSE_OK      1
`define CNT_OPEN_FAIL     2
`define CNT_CLOSE_FAIL    3
`define RST_LOCAL_SEL     1'b0
`define RST_ARMED         1'b0
`endif

// [core/object_ctrl_pkg.sv]
// types of the switchgear object control block
package object_ctrl_pkg;
`include "object_ctrl_consts.svh"

   typedef enum logic [1:0] {
      OBJ_BREAKER, OBJ_WD_BREAKER, OBJ_DISC_MC, OBJ_DISC_GND
   } obj_kind_type;

   typedef enum logic [1:0] {
      POS_INTERMEDIATE, POS_OPEN, POS_CLOSED, POS_BAD
   } pos_type;

   typedef enum logic [2:0] {
      CART_POSITION_INTERMEDIATE, CART_WITHDRAWN, CART_INSERTED,
      CART_POSITION_INVALID, CART_UNUSED
   } cart_pos_type;

   typedef enum logic [1:0] {
      SRC_LOCAL, SRC_REMOTE, SRC_AUTO
   } source_type;

   typedef enum logic [1:0] {
      READY_UNUSED, READY_HIGH, READY_LOW
   } ready_mode_type;

   typedef enum logic [3:0] {
      ST_NORMAL, ST_OPEN_REQ, ST_CLOSE_REQ, ST_OPEN_SIGNAL,
      ST_CLOSE_SIGNAL, ST_WAIT_NOT_READY, ST_WAIT_NO_SYNC,
      ST_READY_FAILURE, ST_SYNC_FAILURE, ST_OPEN_TIMEOUT,
      ST_CLOSE_TIMEOUT, ST_USER_OPEN_REQUEST, ST_USER_CLOSE_REQUEST
   } status_type;

   typedef struct packed {
      obj_kind_type   objKind;
      logic           singleInput;
      logic           useSync;
      logic           syncFromPin;
      ready_mode_type readyMode;
      logic           selectBeforeExecute;
      logic           forceEnable;
      status_type     forceState;
   } cfg_type;

   typedef struct packed {
      logic       openReq;
      logic       closeReq;
      logic       selectReq;
      source_type source;
   } cmd_type;

   typedef struct packed {
      logic openStatus;
      logic closeStatus;
      logic cartIn;
      logic cartOut;
      logic readyIn;
      logic extSync;
   } pins_type;

   typedef struct packed {
      logic openAllowed;
      logic closeAllowed;
      logic objectReady;
      logic syncOk;
   } flags_type;
endpackage

// [core/position_decoder.sv]
// two-contact position decoder
`timescale 1ns/1ps
module position_decoder (
   input  wire logic                    awayIn,
   input  wire logic                    homeIn,
   output object_ctrl_pkg::pos_type     pos
);
   import object_ctrl_pkg::*;

   // neither active, both active, or one of them
   assign pos = (!awayIn && !homeIn) ? POS_INTERMEDIATE :
                ( awayIn &&  homeIn) ? POS_BAD :
                awayIn ? POS_OPEN : POS_CLOSED;
endmodule

// [core/request_counter.sv]
// saturating request counter with clear
`timescale 1ns/1ps
`include "object_ctrl_consts.svh"
module request_counter #(
   parameter int WIDTH = `COUNT_WIDTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             inc,
   input  wire logic             clr,
   output logic [WIDTH-1:0]      count
);
   import object_ctrl_pkg::*;

   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   wire              atTop = &count_reg;

   assign count_next = clr ? '0 :
                       (inc && !atTop) ? count_reg + 1'b1 : count_reg;
   assign count = count_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end
endmodule

// [verif/contact_model.sv]
// breaker auxiliary contact model driven by the relay commands
`timescale 1ns/1ps
module contact_model #(
   parameter int TRAVEL = 2
) (
   input  wire logic                      sys_clk,
   input  wire logic                      openCmd,
   input  wire logic                      closeCmd,
   input  wire logic                      manual,
   input  wire object_ctrl_pkg::pins_type manPins,
   output object_ctrl_pkg::pins_type      pins
);
   import object_ctrl_pkg::*;

   logic isClosed  = 1'b0;
   int   travelCnt = 0;
   logic moving;

   assign moving = (openCmd || closeCmd) && (travelCnt < TRAVEL);

   always @(posedge sys_clk) begin
      if (openCmd || closeCmd) begin
         if (travelCnt == TRAVEL) begin
            isClosed <= closeCmd;
         end else begin
            travelCnt <= travelCnt + 1;
         end
      end else begin
         travelCnt <= 0;
      end
   end

   // paired contacts, both released in travel
   always_comb begin
      pins = manPins;
      if (!manual) begin
         pins.openStatus  = !moving && !isClosed;
         pins.closeStatus = !moving && isClosed;
      end
   end
endmodule

// [verif/testbench.sv]
// self-checking bench of the object control block
`timescale 1ns/1ps
`include "object_ctrl_consts.svh"
module testbench;
   import object_ctrl_pkg::*;
   localparam int PLEN = 4;
   logic                                  sys_clk = 1'b0;
   logic                                  rst     = 1'b1;
   cfg_type                               cfg;
   pins_type                              pins;
   pins_type                              manPins;
   cmd_type                               cmd;
   logic                                  manual;
   logic                                  syncResult;
   logic                                  setLocal;
   logic                                  setRemote;
   logic                                  statClear;
   logic                                  nameLoad;
   logic [`NAME_CHARS*8-1:0]              nameIn;
   logic [`NAME_CHARS*8-1:0]              objectName;
   logic                                  openCmd;
   logic                                  closeCmd;
   logic                                  localActive;
   pos_type                               breakerPos;
   cart_pos_type                          cartPos;
   flags_type                             flags;
   status_type                            objStatus;
   logic [`CNT_NUM-1:0][`COUNT_WIDTH-1:0] requestCounts;
   int                                    miscompares = 0;
   int                                    compares    = 0;
   int                                    nOpen;
   int                                    nClose;

   always #25 sys_clk = ~sys_clk;

   switchgear_object_control_monitor #(.PULSE_LEN(PLEN))
   u_switchgear_object_control_monitor (
      .sys_clk(sys_clk), .rst(rst), .cfg(cfg), .pins(pins),
      .syncResult(syncResult), .cmd(cmd), .setLocal(setLocal),
      .setRemote(setRemote), .statClear(statClear),
      .nameLoad(nameLoad), .nameIn(nameIn), .openCmd(openCmd),
      .closeCmd(closeCmd), .breakerPos(breakerPos),
      .cartPos(cartPos), .flags(flags), .objStatus(objStatus),
      .localActive(localActive), .requestCounts(requestCounts),
      .objectName(objectName)
   );

   contact_model u_contact_model (
      .sys_clk(sys_clk), .openCmd(openCmd), .closeCmd(closeCmd),
      .manual(manual), .manPins(manPins), .pins(pins)
   );

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   // request pulse, then count relay cycles
   task automatic req(input logic op, input logic sel,
                      input source_type src);
      cmd = '{openReq: op, closeReq: !op && !sel, selectReq: sel,
              source: src};
      tick(1);
      cmd = '0;
      nOpen = 0;
      nClose = 0;
      for (int i = 0; i < PLEN + 6; i++) begin
         nOpen += int'(openCmd);
         nClose += int'(closeCmd);
         tick(1);
      end
   endtask

   task automatic final_report();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(4000 * 50);
      miscompares++;
      final_report();
   end

   initial begin
      cfg = '0;
      manPins = '0;
      cmd = '0;
      manual = 1'b1;
      {syncResult, setLocal, setRemote, statClear, nameLoad} = '0;
      nameIn = '0;
      tick(2);
      rst = 1'b0;
      tick(4);
      cmp(localActive, 32'h0000_0000);
      cmp(cartPos, CART_UNUSED);
      manPins = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
      tick(5);
      cmp(breakerPos, POS_BAD);
      cmp(cartPos, CART_UNUSED);
      cfg.objKind = OBJ_WD_BREAKER;
      tick(3);
      cmp(cartPos, CART_POSITION_INVALID);
      manPins = '0;
      tick(5);
      cmp(breakerPos, POS_INTERMEDIATE);
      cmp(cartPos, CART_POSITION_INTERMEDIATE);
      manPins.cartIn = 1'b1;
      cfg.singleInput = 1'b1;
      tick(5);
      cmp(breakerPos, POS_CLOSED);
      cmp(cartPos, CART_INSERTED);
      cfg = '0;
      manPins = '0;
      manual = 1'b0;
      tick(5);
      $display("test positions done");
      req(1'b1, 1'b0, SRC_LOCAL);
      cmp(nOpen, 32'h0000_0000);
      req(1'b1, 1'b0, SRC_REMOTE);
      cmp(nOpen, PLEN);
      cmp(nClose, 32'h0000_0000);
      tick(5);
      cmp(breakerPos, POS_OPEN);
      setLocal = 1'b1;
      tick(1);
      setLocal = 1'b0;
      tick(1);
      cmp(localActive, 32'h0000_0001);
      req(1'b0, 1'b0, SRC_REMOTE);
      cmp(nClose, 32'h0000_0000);
      req(1'b0, 1'b0, SRC_LOCAL);
      cmp(nClose, PLEN);
      setRemote = 1'b1;
      tick(1);
      setRemote = 1'b0;
      tick(1);
      cmp(requestCounts[`CNT_OPEN_OK], 32'h0000_0001);
      cmp(requestCounts[`CNT_CLOSE_OK], 32'h0000_0001);
      $display("test authority done");
      cfg.useSync = 1'b1;
      req(1'b1, 1'b0, SRC_AUTO);
      tick(2);
      cmp(flags.syncOk, 32'h0000_0000);
      cmp(flags.closeAllowed, 32'h0000_0000);
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, 32'h0000_0000);
      cmp(requestCounts[`CNT_CLOSE_FAIL], 32'h0000_0001);
      cmp(objStatus, ST_SYNC_FAILURE);
      syncResult = 1'b1;
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, PLEN);
      syncResult = 1'b0;
      cfg.syncFromPin = 1'b1;
      manPins.extSync = 1'b1;
      tick(4);
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, PLEN);
      cfg = '0;
      cfg.readyMode = READY_LOW;
      manPins.readyIn = 1'b1;
      req(1'b1, 1'b0, SRC_AUTO);
      tick(4);
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, 32'h0000_0000);
      cmp(requestCounts[`CNT_CLOSE_FAIL], 32'h0000_0002);
      cmp(objStatus, ST_READY_FAILURE);
      cmp(flags.objectReady, 32'h0000_0000);
      cmp(flags.openAllowed, 32'h0000_0001);
      manPins.readyIn = 1'b0;
      tick(4);
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, PLEN);
      cfg.readyMode = READY_HIGH;
      tick(1);
      cmp(flags.objectReady, 32'h0000_0000);
      manPins.readyIn = 1'b1;
      tick(4);
      cmp(flags.objectReady, 32'h0000_0001);
      $display("test close gates done");
      cfg = '0;
      cfg.selectBeforeExecute = 1'b1;
      req(1'b1, 1'b0, SRC_REMOTE);
      cmp(nOpen, 32'h0000_0000);
      req(1'b0, 1'b1, SRC_REMOTE);
      req(1'b1, 1'b0, SRC_REMOTE);
      cmp(nOpen, PLEN);
      req(1'b0, 1'b0, SRC_REMOTE);
      cmp(nClose, 32'h0000_0000);
      req(1'b0, 1'b1, SRC_REMOTE);
      req(1'b0, 1'b0, SRC_REMOTE);
      cmp(nClose, PLEN);
      cfg = '0;
      cfg.objKind = OBJ_DISC_GND;
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, 32'h0000_0000);
      cfg.objKind = OBJ_DISC_MC;
      cfg.useSync = 1'b1;
      req(1'b0, 1'b0, SRC_AUTO);
      cmp(nClose, PLEN);
      cfg = '0;
      cmd = '{openReq: 1'b1, closeReq: 1'b0, selectReq: 1'b0,
              source: SRC_AUTO};
      tick(2);
      cmd = '0;
      tick(PLEN + 4);
      cmp(requestCounts[`CNT_OPEN_FAIL], 32'h0000_0001);
      $display("test modes done");
      cfg.forceState = ST_WAIT_NO_SYNC;
      tick(2);
      cmp(objStatus, ST_NORMAL);
      cfg.forceEnable = 1'b1;
      tick(2);
      cmp(objStatus, ST_WAIT_NO_SYNC);
      cmp(openCmd, 32'h0000_0000);
      cfg = '0;
      statClear = 1'b1;
      tick(1);
      statClear = 1'b0;
      tick(1);
      for (int i = 0; i < `CNT_NUM; i++) begin
         cmp(requestCounts[i], 32'h0000_0000);
      end
      nameIn = {8{32'h4D5A_0A11}};
      nameIn[7:0] = 8'h3C;
      nameLoad = 1'b1;
      tick(1);
      nameLoad = 1'b0;
      tick(1);
      cmp(objectName[31:0], 32'h4D5A_0A3C);
      cmp(objectName[255:224], 32'h4D5A_0A11);
      $display("test force, clear, name done");
      final_report();
   end
endmodule
